// File: shared/drive_cmd_defines.vh
// Bit positions, reset values and timing counts of the drive command word
`ifndef DRIVE_CMD_DEFINES_VH
`define DRIVE_CMD_DEFINES_VH

// ****************************************
// Command word bit positions
// ****************************************
`define CW_NORMAL_STOP_N_BIT 0
`define CW_COAST_STOP_N_BIT 1
`define CW_EMERGENCY_STOP_N_BIT 2
`define CW_RUN_ENABLE_BIT 3
`define CW_RAMP_OUT_ENABLE_BIT 4
`define CW_RAMP_RUN_BIT 5
`define CW_RAMP_IN_ENABLE_BIT 6
`define CW_FAULT_RESET_BIT 7
`define CW_REMOTE_ENABLE_BIT 10
`define CW_LOCATION_SELECT_BIT 11

// ****************************************
// Reset values and widths
// ****************************************
`define CW_WIDTH 16
`define CW_RESET_VALUE 16'h0000
`define CW_USED_MASK 16'h0CFF

// ****************************************
// Drive state codes
// ****************************************
`define ST_SWITCH_ON_INHIBITED 3'h0
`define ST_READY_TO_SWITCH_ON 3'h1
`define ST_READY_TO_OPERATE 3'h2
`define ST_OPERATION_ENABLED 3'h3
`define ST_NORMAL_STOP 3'h4
`define ST_COAST_STOP 3'h5
`define ST_EMERGENCY_STOP 3'h6
`define ST_FAULT 3'h7

// ****************************************
// Timing
// ****************************************
`define CLK_FREQ_MHZ 200
`define ESTOP_TIME_US 1000
`define ESTOP_CYCLES (`ESTOP_TIME_US * `CLK_FREQ_MHZ)

`endif

// File: rtl/cmd_word_capture.v
// Captures each new command word and flags the reset bit's rising edge
`timescale 1ns/100ps
`include "drive_cmd_defines.vh"

module cmd_word_capture #(
    parameter WIDTH = `CW_WIDTH
) (
    input wire ref_clk_i,
    input wire rst_i,
    input wire word_valid_i,
    input wire [WIDTH-1:0] word_i,
    output reg [WIDTH-1:0] word_o,
    output reg fault_reset_edge_o
);

    // Store word with reserved bits masked, detect reset edge vs last word
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            word_o <= `CW_RESET_VALUE;
            fault_reset_edge_o <= 1'b0;
        end else begin
            fault_reset_edge_o <= 1'b0;
            if (word_valid_i) begin
                word_o <= word_i & `CW_USED_MASK;
                fault_reset_edge_o <= word_i[`CW_FAULT_RESET_BIT] &
                    ~word_o[`CW_FAULT_RESET_BIT];
            end
        end
    end

endmodule

// File: rtl/stop_timer.v
// Down counter bounding the emergency stop time
`timescale 1ns/100ps
`include "drive_cmd_defines.vh"

module stop_timer #(
    parameter COUNT = `ESTOP_CYCLES
) (
    input wire ref_clk_i,
    input wire rst_i,
    input wire start_i,
    input wire run_i,
    output reg done_o
);

    reg [31:0] count_r;

    // Load on start, count down while run, pulse done at zero
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            count_r <= 32'h0000_0000;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                count_r <= COUNT - 1;
            end else if (run_i) begin
                if (count_r == 32'h0000_0000) begin
                    // Toggle so the state leaving a cycle late sees one pulse
                    done_o <= ~done_o;
                end else begin
                    count_r <= count_r - 32'h0000_0001;
                end
            end
        end
    end

endmodule

// File: rtl/drive_command_word_decoder.v
// Decoder of the drive command word into drive state and control levels
`timescale 1ns/100ps
`include "drive_cmd_defines.vh"

// What this block does
// - Bit0 low: ramp stop, then ready
// - Bit1 low: coast stop, then inhibited
// - Bit2 low: timed emergency stop, then inhibited
// - Bit3 set enables operation, clear drops to ready to operate
// - Bit3 drives run enable when fieldbus-sourced
// - Bit4 low forces ramp output zero
// - Bit5 low holds ramp output
// - Bit6 low forces ramp input zero
// - Bit7 rising edge resets fault
// - Bit10 low: only bits 0-2 act
// - Bit11 picks second external location
module drive_command_word_decoder #(
    parameter ESTOP_COUNT = `ESTOP_CYCLES
) (
    input wire ref_clk_i,
    input wire rst_i,
    input wire cmd_valid_i,
    input wire [`CW_WIDTH-1:0] drive_command_word_i,
    input wire run_enable_from_bus_i,
    input wire ramp_in_from_bus_i,
    input wire fault_reset_from_bus_i,
    input wire location_from_bus_i,
    input wire ext_run_enable_i,
    input wire fault_i,
    input wire motor_stopped_i,
    output reg [2:0] drive_state_o,
    output reg run_enable_o,
    output reg ramp_out_zero_o,
    output reg ramp_hold_o,
    output reg ramp_in_zero_o,
    output reg fault_reset_o,
    output reg external_location_select_o,
    output reg normal_stop_state_o,
    output reg coast_stop_state_o,
    output reg emergency_stop_state_o,
    output reg emergency_stop_timeout_o,
    output reg [`CW_WIDTH-1:0] drive_command_word_o
);

    // ****************************************
    // Command word capture and emergency stop timer
    // ****************************************
    wire [`CW_WIDTH-1:0] cw;
    wire reset_edge;
    wire estop_done;
    reg [2:0] state_r;
    reg [2:0] state_nxt;

    cmd_word_capture #(
        .WIDTH(`CW_WIDTH)
    ) u_capture (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .word_valid_i(cmd_valid_i),
        .word_i(drive_command_word_i),
        .word_o(cw),
        .fault_reset_edge_o(reset_edge)
    );

    stop_timer #(
        .COUNT(ESTOP_COUNT)
    ) u_estop (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .start_i(state_r != `ST_EMERGENCY_STOP &&
                 state_nxt == `ST_EMERGENCY_STOP),
        .run_i(state_r == `ST_EMERGENCY_STOP),
        .done_o(estop_done)
    );

    // ****************************************
    // Decoded command bits
    // ****************************************
    wire normal_stop_n = cw[`CW_NORMAL_STOP_N_BIT];
    wire coast_stop_n = cw[`CW_COAST_STOP_N_BIT];
    wire emergency_stop_n = cw[`CW_EMERGENCY_STOP_N_BIT];
    wire remote = cw[`CW_REMOTE_ENABLE_BIT];
    // Remaining bits only count with fieldbus control enabled
    wire op_enable = remote & cw[`CW_RUN_ENABLE_BIT];
    wire bus_reset = remote & fault_reset_from_bus_i & reset_edge;
    wire run_en = run_enable_from_bus_i ? op_enable :
        ext_run_enable_i;

    // ****************************************
    // Drive state machine
    // ****************************************
    always @* begin
        state_nxt = state_r;
        case (state_r)
            `ST_FAULT: begin
                if (bus_reset)
                    state_nxt = `ST_SWITCH_ON_INHIBITED;
            end
            `ST_COAST_STOP: begin
                if (motor_stopped_i)
                    state_nxt = `ST_SWITCH_ON_INHIBITED;
            end
            `ST_EMERGENCY_STOP: begin
                if (motor_stopped_i || estop_done)
                    state_nxt = `ST_SWITCH_ON_INHIBITED;
            end
            `ST_NORMAL_STOP: begin
                if (!coast_stop_n)
                    state_nxt = `ST_COAST_STOP;
                else if (!emergency_stop_n)
                    state_nxt = `ST_EMERGENCY_STOP;
                else if (motor_stopped_i)
                    state_nxt = `ST_READY_TO_SWITCH_ON;
            end
            `ST_SWITCH_ON_INHIBITED: begin
                if (coast_stop_n && emergency_stop_n && !normal_stop_n)
                    state_nxt = `ST_READY_TO_SWITCH_ON;
            end
            `ST_READY_TO_SWITCH_ON,
            `ST_READY_TO_OPERATE,
            `ST_OPERATION_ENABLED: begin
                if (!coast_stop_n)
                    state_nxt = `ST_COAST_STOP;
                else if (!emergency_stop_n)
                    state_nxt = `ST_EMERGENCY_STOP;
                else if (!normal_stop_n)
                    state_nxt = (state_r == `ST_READY_TO_SWITCH_ON) ?
                        `ST_READY_TO_SWITCH_ON : `ST_NORMAL_STOP;
                else if (op_enable && run_en)
                    state_nxt = `ST_OPERATION_ENABLED;
                else
                    state_nxt = `ST_READY_TO_OPERATE;
            end
            default: state_nxt = `ST_SWITCH_ON_INHIBITED;
        endcase
        // Fault overrides every state except an active fault reset
        if (fault_i && state_r != `ST_FAULT)
            state_nxt = `ST_FAULT;
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_r <= `ST_SWITCH_ON_INHIBITED;
            drive_state_o <= `ST_SWITCH_ON_INHIBITED;
            run_enable_o <= 1'b0;
            ramp_out_zero_o <= 1'b1;
            ramp_hold_o <= 1'b1;
            ramp_in_zero_o <= 1'b1;
            fault_reset_o <= 1'b0;
            external_location_select_o <= 1'b0;
            normal_stop_state_o <= 1'b0;
            coast_stop_state_o <= 1'b0;
            emergency_stop_state_o <= 1'b0;
            emergency_stop_timeout_o <= 1'b0;
            drive_command_word_o <= `CW_RESET_VALUE;
        end else begin
            state_r <= state_nxt;
            drive_state_o <= state_nxt;
            run_enable_o <= run_enable_from_bus_i & op_enable;
            // Ramp output released only while operation is enabled; hold and input ignore state
            ramp_out_zero_o <= !(state_nxt == `ST_OPERATION_ENABLED &&
                remote && cw[`CW_RAMP_OUT_ENABLE_BIT]);
            ramp_hold_o <= !(remote && cw[`CW_RAMP_RUN_BIT]);
            ramp_in_zero_o <= ramp_in_from_bus_i &&
                !(remote && cw[`CW_RAMP_IN_ENABLE_BIT]);
            fault_reset_o <= bus_reset && (state_r == `ST_FAULT);
            if (remote && location_from_bus_i)
                external_location_select_o <=
                    cw[`CW_LOCATION_SELECT_BIT];
            normal_stop_state_o <= (state_nxt == `ST_NORMAL_STOP);
            coast_stop_state_o <= (state_nxt == `ST_COAST_STOP);
            emergency_stop_state_o <= (state_nxt == `ST_EMERGENCY_STOP);
            emergency_stop_timeout_o <= estop_done;
            drive_command_word_o <= cw;
        end
    end

endmodule

// File: verification/drive_cmd_monitor.sv
// Checker of the command word decoder port behaviour
`timescale 1ns/100ps
`include "drive_cmd_defines.vh"
module drive_cmd_monitor (
    input wire ref_clk_i,
    input wire rst_i,
    input wire cmd_valid_i,
    input wire [`CW_WIDTH-1:0] drive_command_word_i,
    input wire run_enable_from_bus_i,
    input wire ramp_in_from_bus_i,
    input wire location_from_bus_i,
    input wire fault_i,
    input wire [2:0] drive_state_o,
    input wire run_enable_o,
    input wire ramp_out_zero_o,
    input wire ramp_hold_o,
    input wire ramp_in_zero_o,
    input wire fault_reset_o,
    input wire external_location_select_o,
    input wire [`CW_WIDTH-1:0] drive_command_word_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    wire [15:0] w = drive_command_word_i;
    // New word while enabled and fault free
    sequence op_s;
        cmd_valid_i && !fault_i && drive_state_o == `ST_OPERATION_ENABLED;
    endsequence
    AST_WORD: assert property (cmd_valid_i |-> ##2
        drive_command_word_o == (w & `CW_USED_MASK)) else $error("bad word");
    AST_RAMP: assert property (cmd_valid_i && w[10] |-> ##2
        ramp_out_zero_o == !(w[4] && drive_state_o == `ST_OPERATION_ENABLED)
        && ramp_hold_o == !w[5]) else $error("ramp");
    AST_RIN: assert property (cmd_valid_i && w[10] |-> ##2
        ramp_in_zero_o == (ramp_in_from_bus_i && !w[6])) else $error("rin");
    AST_RUN: assert property (cmd_valid_i && w[10] && run_enable_from_bus_i
        |-> ##2 run_enable_o == w[3]) else $error("run enable");
    AST_LOC: assert property (cmd_valid_i && w[10] && location_from_bus_i
        |-> ##2 external_location_select_o == w[11]) else $error("location");
    AST_FRST: assert property (fault_reset_o |->
        $past(drive_state_o) == `ST_FAULT ##1 !fault_reset_o) else $error("frst");
    AST_STOP1: assert property (op_s and w[2:0] == 3'b110 |-> ##2
        drive_state_o == `ST_NORMAL_STOP) else $error("normal stop");
    AST_STOP2: assert property (op_s and !w[1] |-> ##2
        drive_state_o == `ST_COAST_STOP) else $error("coast stop");
    AST_STOP3: assert property (op_s and w[2:1] == 2'b01 |-> ##2
        drive_state_o == `ST_EMERGENCY_STOP) else $error("estop");
endmodule

// File: verification/client_station_model.sv
// Client station model sending command words
`timescale 1ns/100ps
module client_station_model (
    input wire ref_clk_i,
    input wire send_i,
    input wire [15:0] word_i,
    output reg cmd_valid_o,
    output reg [15:0] word_o
);
    initial {cmd_valid_o, word_o} = 17'h0_0000;
    // Registered send; idle bus inverts the word every cycle
    always @(posedge ref_clk_i) begin
        cmd_valid_o <= send_i;
        word_o <= send_i ? word_i : ~word_o;
    end
endmodule

// File: verification/drive_command_word_decoder_bench.sv
// Bench of the command word decoder
`timescale 1ns/100ps
module drive_command_word_decoder_bench;
    reg ref_clk_i = 0;
    reg rst_i = 1;
    reg send = 0;
    reg [15:0] wd = 16'h0000;
    reg [6:0] src = 7'h0F; // stopped, fault, ext run, bus sources
    wire cv, ren, roz, rh, riz, frst, loc, tmo, ns, cs, es;
    wire [15:0] cw, wo;
    wire [2:0] st;
    integer err_total = 0;
    integer samples_checked = 0;
    integer cyc = 0;
    integer k;
    // Clock and cycle ceiling
    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            tally_and_finish;
        end
    end
    client_station_model client_station_model_i (.ref_clk_i(ref_clk_i),
        .send_i(send), .word_i(wd), .cmd_valid_o(cv), .word_o(cw));
    drive_command_word_decoder #(.ESTOP_COUNT(20)) drive_command_word_decoder_i (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cmd_valid_i(cv),
        .drive_command_word_i(cw), .run_enable_from_bus_i(src[3]),
        .ramp_in_from_bus_i(src[2]), .fault_reset_from_bus_i(src[1]),
        .location_from_bus_i(src[0]), .ext_run_enable_i(src[4]),
        .fault_i(src[5]), .motor_stopped_i(src[6]), .drive_state_o(st),
        .run_enable_o(ren), .ramp_out_zero_o(roz), .ramp_hold_o(rh),
        .ramp_in_zero_o(riz), .fault_reset_o(frst),
        .external_location_select_o(loc), .normal_stop_state_o(ns),
        .coast_stop_state_o(cs), .emergency_stop_state_o(es),
        .emergency_stop_timeout_o(tmo), .drive_command_word_o(wo));
    // Compare and count
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // One word, then wait until outputs settle
    task cmd(input [15:0] w);
        begin
            @(posedge ref_clk_i);
            send <= 1'b1;
            wd <= w;
            @(posedge ref_clk_i);
            send <= 1'b0;
            repeat (2) @(posedge ref_clk_i);
            #1;
        end
    endtask
    task setsrc(input [6:0] v);
        begin
            @(posedge ref_clk_i);
            src <= v;
            repeat (3) @(posedge ref_clk_i);
            #1;
        end
    endtask
    task tally_and_finish;
        begin
            if (err_total == 0 && samples_checked > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        cmd(16'h0406);
        chk("state", st, 16'h0001);
        cmd(16'h040F);
        chk("state", st, 16'h0003);
        chk("run_en", ren, 16'h0001);
        cmd(16'hF77F);
        chk("word", wo, 16'h047F);
        chk("forces", {roz, rh, riz}, 16'h0000);
        cmd(16'h0C0F);
        chk("forces", {roz, rh, riz}, 16'h0007);
        chk("loc", loc, 16'h0001);
        cmd(16'h007E);
        chk("state", st, 16'h0004);
        chk("stops", {ns, cs, es}, 16'h0004);
        chk("forces", {roz, rh, riz}, 16'h0007);
        chk("loc", loc, 16'h0001);
        setsrc(7'h4F);
        chk("state", st, 16'h0001);
        setsrc(7'h0F);
        cmd(16'h040F);
        cmd(16'h040D);
        chk("state", st, 16'h0005);
        chk("stops", {ns, cs, es}, 16'h0002);
        setsrc(7'h4F);
        chk("state", st, 16'h0000);
        setsrc(7'h0F);
        cmd(16'h0406);
        cmd(16'h040F);
        cmd(16'h040B);
        chk("state", st, 16'h0006);
        chk("stops", {ns, cs, es}, 16'h0001);
        for (k = 0; k < 40 && tmo !== 1'b1; k = k + 1) begin
            @(posedge ref_clk_i);
            #1;
        end
        chk("timeout", tmo, 16'h0001);
        setsrc(7'h2F);
        chk("state", st, 16'h0007);
        cmd(16'h0406);
        setsrc(7'h0F);
        cmd(16'h0486);
        chk("frst", frst, 16'h0001);
        chk("state", st, 16'h0000);
        tally_and_finish;
    end
endmodule
bind drive_command_word_decoder drive_cmd_monitor drive_cmd_monitor_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
    .drive_command_word_i(drive_command_word_i),
    .run_enable_from_bus_i(run_enable_from_bus_i),
    .ramp_in_from_bus_i(ramp_in_from_bus_i),
    .location_from_bus_i(location_from_bus_i), .fault_i(fault_i),
    .drive_state_o(drive_state_o), .run_enable_o(run_enable_o),
    .ramp_out_zero_o(ramp_out_zero_o), .ramp_hold_o(ramp_hold_o),
    .ramp_in_zero_o(ramp_in_zero_o), .fault_reset_o(fault_reset_o),
    .external_location_select_o(external_location_select_o),
    .drive_command_word_o(drive_command_word_o));
